// ==== logic/seg_lcd_map.svh ====
`ifndef SEG_LCD_MAP_SVH
`define SEG_LCD_MAP_SVH
// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_HZ        200000000
`define FAST_LOAD_PERIOD_US 10000
`define FAST_LOAD_PERIOD_CYC ((`CLK_FREQ_HZ / 1000000) * `FAST_LOAD_PERIOD_US)
`define ON_TIME_UNIT_US    400
`define ON_TIME_UNIT_CYC   ((`CLK_FREQ_HZ / 1000000) * `ON_TIME_UNIT_US)
// ****************************************
// Field layout
// ****************************************
`define DIGIT_BITS         8
`define PATTERN_BITS       56
`define POS_FIELD_BITS     3
`define MUX_OFF            2'h0
`define MUX_2X             2'h1
`define MUX_3X             2'h2
`define MUX_4X             2'h3
`define PATTERN_2X_BITS    32
`define PATTERN_3X_BITS    40
`define SYMBOL_3X_LO       40
`define SYMBOL_3X_HI       44
`define BLANK_PATTERN      8'h00
`define MINUS_PATTERN      8'h40
`define DOT_BIT            7
`endif

// ==== logic/seg_lcd_pkg.sv ====
package seg_lcd_pkg;
    // Four drive levels
    typedef enum logic [1:0] {
        LVL_GND    = 2'b00,
        LVL_THIRD  = 2'b01,
        LVL_2THIRD = 2'b10,
        LVL_FULL   = 2'b11
    } drive_level_t;

    typedef struct packed {
        logic       direct_drive;
        logic [1:0] fast_load_periods;
        logic [1:0] fast_load_divider_periods;
        logic       pump_charge_resistor_sel;
        logic [1:0] divider_res;
        logic [1:0] recharge_interval;
        logic [1:0] mux_mode;
        logic [2:0] on_time;
    } lcd_cfg_t;

    typedef struct packed {
        logic       low_ohm_divider;
        logic       pump_enable;
        logic       charge_1k;
        logic [1:0] divider_res;
        logic       recharge_now;
        logic       driver_low_res;
    } lcd_analog_t;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_DIV  = 2'b01,
        CONV_DONE = 2'b10
    } conv_state_t;
endpackage

// ==== logic/segment_lcd_driver.sv ====
`timescale 1ns/1ps
// Operation
// - Direct drive: supply straight to outputs, no pump, drivers low resistance.
// - Fast-load count sets 10 ms periods of low-ohmic divider after switching.
// - Charge resistor bit: 0 picks 200 Ohm, 1 picks 1 kOhm; not in direct drive.
// - Divider field codes 0..3 select 15k, 200k, 800k, 1600k cross resistance.
// - Recharge every cycle, second or fourth cycle; ignored in direct drive.
// - Every output drives ground, one third, two thirds or full voltage.
// - One byte per digit, bit0 segment a to bit6 g, bit7 dot; 1 lights.
// - Pattern bits live in registers 13 to 15, layout independent of mode.
// - Digit n uses bits 8n+7 to 8n; digit 6 is bits 55 to 48.
// - In 2x multiplex only digits 0 to 3 are shown.
// - In 3x multiplex five digits plus symbol bits 40 to 44 are shown.
// - Digit conversion maps low nibble 0..9 to standard segment byte.
// - Number conversion: signed 24 bit, dot position, blank zeros, keep 55..48.
// - New patterns are shown only after the update command.
// - Position map gives each segment letter a 3-bit crossing field.
// - Multiplex field: 0 off, 1/2/3 select 2x, 3x, 4x.
// - On-time code 0 gives 8.0 ms down to 1.2 ms for code 7.
`include "seg_lcd_map.svh"
module segment_lcd_driver #(
    parameter int unsigned  NUM_SEG_LINES = 16,
    parameter int unsigned  FAST_LOAD_CYC = `FAST_LOAD_PERIOD_CYC,
    parameter int unsigned  ON_UNIT_CYC   = `ON_TIME_UNIT_CYC
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire seg_lcd_pkg::lcd_cfg_t         cfg,
    input  wire logic [23:0]                   seg_pos_map,
    input  wire logic                          pattern_we,
    input  wire logic [1:0]                    pattern_reg_sel,
    input  wire logic [23:0]                   pattern_wdata,
    input  wire logic                          display_update,
    input  wire logic                          digit_to_segment_op,
    input  wire logic [3:0]                    digit_value,
    output logic      [7:0]                    digit_segments,
    input  wire logic                          number_to_segments_routine,
    input  wire logic [23:0]                   number_value,
    input  wire logic [2:0]                    dot_position,
    output logic                               conv_busy,
    output logic [55:0]                        pattern_shadow,
    output seg_lcd_pkg::drive_level_t [3:0]    com_level,
    output seg_lcd_pkg::drive_level_t [NUM_SEG_LINES-1:0] seg_level,
    output seg_lcd_pkg::lcd_analog_t           analog
);
    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [7:0] digit_code(input logic [3:0] d);
        case (d)
            4'h0: digit_code = 8'h3F;
            4'h1: digit_code = 8'h06;
            4'h2: digit_code = 8'h5B;
            4'h3: digit_code = 8'h4F;
            4'h4: digit_code = 8'h66;
            4'h5: digit_code = 8'h6D;
            4'h6: digit_code = 8'h7D;
            4'h7: digit_code = 8'h07;
            4'h8: digit_code = 8'h7F;
            4'h9: digit_code = 8'h6F;
            default: digit_code = `BLANK_PATTERN;
        endcase
    endfunction

    function automatic logic [1:0] num_commons(input logic [1:0] m);
        case (m)
            `MUX_2X: num_commons = 2'd1;
            `MUX_3X: num_commons = 2'd2;
            `MUX_4X: num_commons = 2'd3;
            default: num_commons = 2'd0;
        endcase
    endfunction

    // ****************************************
    // Pattern registers
    // ****************************************
    logic [55:0] pattern_work;
    logic [55:0] conv_pattern;
    logic        conv_write;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pattern_work <= 56'h0;
        end else if (conv_write) begin
            pattern_work[47:0] <= conv_pattern[47:0];
        end else if (pattern_we) begin
            case (pattern_reg_sel)
                2'd0: pattern_work[23:0]  <= pattern_wdata;
                2'd1: pattern_work[47:24] <= pattern_wdata;
                2'd2: pattern_work[55:48] <= pattern_wdata[7:0];
                default: pattern_work <= pattern_work;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pattern_shadow <= 56'h0;
        end else if (display_update) begin
            pattern_shadow <= pattern_work;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            digit_segments <= 8'h00;
        end else if (digit_to_segment_op) begin
            digit_segments <= digit_code(digit_value);
        end
    end

    // ****************************************
    // Number conversion, one digit per cycle
    // ****************************************
    seg_lcd_pkg::conv_state_t conv_state;
    logic [23:0] conv_mag;
    logic        conv_neg;
    logic [2:0]  conv_idx;
    logic [2:0]  conv_dot;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_state   <= seg_lcd_pkg::CONV_IDLE;
            conv_mag     <= 24'h0;
            conv_neg     <= 1'b0;
            conv_idx     <= 3'd0;
            conv_dot     <= 3'd0;
            conv_pattern <= 56'h0;
        end else begin
            case (conv_state)
                seg_lcd_pkg::CONV_IDLE: begin
                    if (number_to_segments_routine) begin
                        conv_neg     <= number_value[23];
                        conv_mag     <= number_value[23] ? 24'(-number_value) : number_value;
                        conv_idx     <= 3'd0;
                        conv_dot     <= dot_position;
                        conv_pattern <= 56'h0;
                        conv_state   <= seg_lcd_pkg::CONV_DIV;
                    end
                end
                seg_lcd_pkg::CONV_DIV: begin
                    // Leading zeros blank, but digits up to the dot always show
                    if (conv_mag != 24'h0 || conv_idx == 3'd0 || conv_idx <= conv_dot) begin
                        conv_pattern[conv_idx*8 +: 8] <= digit_code(4'(conv_mag % 24'd10))
                            | ((conv_idx == conv_dot && conv_dot != 3'd0) ? 8'h80 : 8'h00);
                    end else if (conv_neg) begin
                        conv_pattern[conv_idx*8 +: 8] <= `MINUS_PATTERN;
                        conv_neg <= 1'b0;
                    end
                    conv_mag <= conv_mag / 24'd10;
                    if (conv_idx == 3'd5) begin
                        conv_state <= seg_lcd_pkg::CONV_DONE;
                    end else begin
                        conv_idx <= conv_idx + 3'd1;
                    end
                end
                seg_lcd_pkg::CONV_DONE: begin
                    conv_state <= seg_lcd_pkg::CONV_IDLE;
                end
                default: conv_state <= seg_lcd_pkg::CONV_IDLE;
            endcase
        end
    end

    assign conv_write = (conv_state == seg_lcd_pkg::CONV_DONE);
    assign conv_busy  = (conv_state != seg_lcd_pkg::CONV_IDLE);

    // ****************************************
    // Mode masking
    // ****************************************
    logic [55:0] shown;
    always_comb begin
        shown = pattern_shadow;
        case (cfg.mux_mode)
            `MUX_2X: shown = {24'h0, pattern_shadow[31:0]};
            `MUX_3X: shown = {11'h0, pattern_shadow[44:0]};
            `MUX_4X: shown = pattern_shadow;
            default: shown = 56'h0;
        endcase
    end

    // ****************************************
    // Slot timing
    // ****************************************
    // On-time: 8.0,4.8,4.0,3.2,2.4,2.0,1.6,1.2 ms in units of 0.4 ms
    logic [4:0] on_units;
    always_comb begin
        case (cfg.on_time)
            3'd0: on_units = 5'd20;
            3'd1: on_units = 5'd12;
            3'd2: on_units = 5'd10;
            3'd3: on_units = 5'd8;
            3'd4: on_units = 5'd6;
            3'd5: on_units = 5'd5;
            3'd6: on_units = 5'd4;
            default: on_units = 5'd3;
        endcase
    end

    logic [31:0] unit_cnt;
    logic [4:0]  slot_units;
    logic        slot_end;
    logic [1:0]  com_idx;
    logic        phase;
    logic        display_on;
    assign display_on = (cfg.mux_mode != `MUX_OFF);
    assign slot_end = (unit_cnt == ON_UNIT_CYC - 1) && (slot_units >= on_units - 5'd1);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unit_cnt   <= 32'h0;
            slot_units <= 5'd0;
        end else if (!display_on || slot_end) begin
            unit_cnt   <= 32'h0;
            slot_units <= 5'd0;
        end else if (unit_cnt == ON_UNIT_CYC - 1) begin
            unit_cnt   <= 32'h0;
            slot_units <= slot_units + 5'd1;
        end else begin
            unit_cnt <= unit_cnt + 32'd1;
        end
    end

    // Frame inverts each full common sweep to keep the glass DC free
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            com_idx <= 2'd0;
            phase   <= 1'b0;
        end else if (!display_on) begin
            com_idx <= 2'd0;
        end else if (slot_end) begin
            if (com_idx >= num_commons(cfg.mux_mode)) begin
                com_idx <= 2'd0;
                phase   <= ~phase;
            end else begin
                com_idx <= com_idx + 2'd1;
            end
        end
    end

    // ****************************************
    // Level generation
    // ****************************************
    // Segment-line lit bits: crossing code = {com[1:0], line bit}; digit groups
    // spread over segment lines two per digit.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            com_level <= '{default: seg_lcd_pkg::LVL_GND};
            seg_level <= '{default: seg_lcd_pkg::LVL_GND};
        end else begin
            for (int c = 0; c < 4; c++) begin
                // Unused commons keep the bias level so no stray crossing darkens
                if (!display_on) begin
                    com_level[c] <= seg_lcd_pkg::LVL_GND;
                end else if (c == com_idx) begin
                    com_level[c] <= phase ? seg_lcd_pkg::LVL_GND : seg_lcd_pkg::LVL_FULL;
                end else begin
                    com_level[c] <= phase ? seg_lcd_pkg::LVL_2THIRD : seg_lcd_pkg::LVL_THIRD;
                end
            end
            for (int s = 0; s < NUM_SEG_LINES; s++) begin
                logic lit;
                lit = 1'b0;
                for (int k = 0; k < 8; k++) begin
                    if (s / 2 < 7 && seg_pos_map[k*3 +: 3] == {com_idx, 1'(s % 2)}) begin
                        lit = lit | shown[(s / 2) * 8 + k];
                    end
                end
                if (!display_on) begin
                    seg_level[s] <= seg_lcd_pkg::LVL_GND;
                end else if (lit) begin
                    seg_level[s] <= phase ? seg_lcd_pkg::LVL_FULL : seg_lcd_pkg::LVL_GND;
                end else begin
                    seg_level[s] <= phase ? seg_lcd_pkg::LVL_THIRD : seg_lcd_pkg::LVL_2THIRD;
                end
            end
        end
    end

    // ****************************************
    // Supply and driver strength
    // ****************************************
    logic [1:0]  recharge_div;
    logic [31:0] fl_cnt;
    logic [2:0]  fl_periods;
    logic        prev_on;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            recharge_div <= 2'd0;
        end else if (slot_end) begin
            recharge_div <= recharge_div + 2'd1;
        end
    end

    // Fast-load window restarts whenever the display is switched on
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fl_cnt     <= 32'h0;
            fl_periods <= 3'd0;
            prev_on    <= 1'b0;
        end else begin
            prev_on <= display_on;
            if (display_on && !prev_on) begin
                fl_cnt     <= 32'h0;
                fl_periods <= {1'b0, cfg.fast_load_divider_periods};
            end else if (fl_periods != 3'd0) begin
                if (fl_cnt == FAST_LOAD_CYC - 1) begin
                    fl_cnt     <= 32'h0;
                    fl_periods <= fl_periods - 3'd1;
                end else begin
                    fl_cnt <= fl_cnt + 32'd1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            analog <= '0;
        end else begin
            analog.low_ohm_divider <= display_on && (fl_periods != 3'd0);
            analog.pump_enable     <= display_on && !cfg.direct_drive;
            analog.driver_low_res  <= cfg.direct_drive;
            analog.charge_1k       <= !cfg.direct_drive && cfg.pump_charge_resistor_sel;
            analog.divider_res     <= cfg.divider_res;
            case (cfg.recharge_interval)
                2'd0: analog.recharge_now <= !cfg.direct_drive && slot_end;
                2'd1: analog.recharge_now <= !cfg.direct_drive && slot_end && recharge_div[0];
                default: analog.recharge_now <= !cfg.direct_drive && slot_end
                                               && (recharge_div == 2'd3);
            endcase
        end
    end
endmodule

// ==== tb/lcd_glass_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Passive glass
// ****************************************
module lcd_glass_model #(
    parameter int unsigned NUM_SEG_LINES = 16
) (
    input  wire seg_lcd_pkg::drive_level_t [3:0]               com_level,
    input  wire seg_lcd_pkg::drive_level_t [NUM_SEG_LINES-1:0] seg_level,
    output logic [3:0][NUM_SEG_LINES-1:0]                      lit
);
    // Only a full-swing crossing turns dark; a third or two thirds stays below threshold
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < NUM_SEG_LINES; s++) begin
                lit[c][s] = ((com_level[c] == seg_lcd_pkg::LVL_FULL) &&
                             (seg_level[s] == seg_lcd_pkg::LVL_GND)) ||
                            ((com_level[c] == seg_lcd_pkg::LVL_GND) &&
                             (seg_level[s] == seg_lcd_pkg::LVL_FULL));
            end
        end
    end
endmodule

// ==== tb/segment_lcd_driver_properties.sv ====
`timescale 1ns/1ps
module segment_lcd_driver_properties #(
    parameter int unsigned NUM_SEG_LINES = 16,
    parameter int unsigned FAST_LOAD_CYC = 8,
    parameter int unsigned ON_UNIT_CYC   = 4
) (
    input wire logic                                       core_clk,
    input wire logic                                       rst,
    input wire seg_lcd_pkg::lcd_cfg_t                      cfg,
    input wire logic [23:0]                                seg_pos_map,
    input wire logic                                       pattern_we,
    input wire logic [1:0]                                 pattern_reg_sel,
    input wire logic [23:0]                                pattern_wdata,
    input wire logic                                       display_update,
    input wire logic                                       digit_to_segment_op,
    input wire logic [3:0]                                 digit_value,
    input wire logic [7:0]                                 digit_segments,
    input wire logic                                       number_to_segments_routine,
    input wire logic [23:0]                                number_value,
    input wire logic [2:0]                                 dot_position,
    input wire logic                                       conv_busy,
    input wire logic [55:0]                                pattern_shadow,
    input wire seg_lcd_pkg::drive_level_t [3:0]               com_level,
    input wire seg_lcd_pkg::drive_level_t [NUM_SEG_LINES-1:0] seg_level,
    input wire seg_lcd_pkg::lcd_analog_t                   analog
);
    // ****************************************
    // Helpers
    // ****************************************
    localparam logic [7:0] SEG_TBL [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
        8'h07, 8'h7F, 8'h6F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] com_rail;
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            com_rail[c] = com_level[c] inside {seg_lcd_pkg::LVL_GND, seg_lcd_pkg::LVL_FULL};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // Properties
    // ****************************************
    a_digit_map: assert property (
        digit_to_segment_op |=> digit_segments == SEG_TBL[$past(digit_value)])
        else $error("digit conversion gave a wrong byte");
    a_digit_hold: assert property (
        !digit_to_segment_op |=> $stable(digit_segments))
        else $error("digit byte changed without a request");
    a_shadow_hold: assert property (
        !display_update |=> $stable(pattern_shadow))
        else $error("shown pattern changed without an update");
    a_busy_len: assert property (
        $rose(conv_busy) |-> conv_busy [*7] ##1 !conv_busy)
        else $error("number conversion busy length wrong");
    a_busy_start: assert property (
        number_to_segments_routine && !conv_busy |=> conv_busy)
        else $error("number conversion did not start");
    a_off_dark: assert property (
        (cfg.mux_mode == 2'h0) [*3] |-> com_level == '0 && seg_level == '0)
        else $error("display off but outputs not grounded");
    a_one_common: assert property (
        (cfg.mux_mode == 2'h3) [*3] |-> $onehot(com_rail))
        else $error("not exactly one common at a rail");
    a_direct_rail: assert property (
        cfg.direct_drive [*3] |-> analog.driver_low_res && !analog.pump_enable)
        else $error("direct drive without low resistance drivers");
    a_no_recharge: assert property (
        cfg.direct_drive [*3] |-> !analog.recharge_now)
        else $error("recharge pulse in direct drive");
    a_divider_code: assert property (
        $stable(cfg.divider_res) [*3] |-> analog.divider_res == cfg.divider_res)
        else $error("divider resistance code not applied");
    a_charge_res: assert property (
        (!cfg.direct_drive && $stable(cfg.pump_charge_resistor_sel)) [*3]
        |-> analog.charge_1k == cfg.pump_charge_resistor_sel)
        else $error("charge resistor selection not applied");
endmodule
bind segment_lcd_driver segment_lcd_driver_properties #(.NUM_SEG_LINES(NUM_SEG_LINES),
    .FAST_LOAD_CYC(FAST_LOAD_CYC), .ON_UNIT_CYC(ON_UNIT_CYC)) i_segment_lcd_driver_properties (
    .core_clk(core_clk), .rst(rst), .cfg(cfg), .seg_pos_map(seg_pos_map),
    .pattern_we(pattern_we), .pattern_reg_sel(pattern_reg_sel), .pattern_wdata(pattern_wdata),
    .display_update(display_update), .digit_to_segment_op(digit_to_segment_op),
    .digit_value(digit_value), .digit_segments(digit_segments),
    .number_to_segments_routine(number_to_segments_routine), .number_value(number_value),
    .dot_position(dot_position), .conv_busy(conv_busy), .pattern_shadow(pattern_shadow),
    .com_level(com_level), .seg_level(seg_level), .analog(analog));

// ==== tb/segment_lcd_driver_test.sv ====
`timescale 1ns/1ps
module segment_lcd_driver_test;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [7:0] SEG_TBL [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
        8'h07, 8'h7F, 8'h6F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic                             core_clk;
    logic                             rst;
    seg_lcd_pkg::lcd_cfg_t            cfg;
    logic [23:0]                      seg_pos_map;
    logic                             pattern_we;
    logic [1:0]                       pattern_reg_sel;
    logic [23:0]                      pattern_wdata;
    logic                             display_update;
    logic                             digit_to_segment_op;
    logic [3:0]                       digit_value;
    logic [7:0]                       digit_segments;
    logic                             number_to_segments_routine;
    logic [23:0]                      number_value;
    logic [2:0]                       dot_position;
    logic                             conv_busy;
    logic [55:0]                      pattern_shadow;
    seg_lcd_pkg::drive_level_t [3:0]  com_level;
    seg_lcd_pkg::drive_level_t [15:0] seg_level;
    seg_lcd_pkg::lcd_analog_t         analog;
    logic [3:0][15:0]                 lit;
    logic [63:0]                      seen;
    int                               err_total;
    int                               comparisons;
    int                               cycles;
    int                               hi;
    // Short counts keep slots and fast-load periods to a few cycles
    segment_lcd_driver #(.NUM_SEG_LINES(16), .FAST_LOAD_CYC(8), .ON_UNIT_CYC(4))
    i_segment_lcd_driver (.core_clk(core_clk), .rst(rst), .cfg(cfg), .seg_pos_map(seg_pos_map),
        .pattern_we(pattern_we), .pattern_reg_sel(pattern_reg_sel),
        .pattern_wdata(pattern_wdata), .display_update(display_update),
        .digit_to_segment_op(digit_to_segment_op), .digit_value(digit_value),
        .digit_segments(digit_segments), .number_to_segments_routine(number_to_segments_routine),
        .number_value(number_value), .dot_position(dot_position), .conv_busy(conv_busy),
        .pattern_shadow(pattern_shadow), .com_level(com_level), .seg_level(seg_level),
        .analog(analog));
    lcd_glass_model #(.NUM_SEG_LINES(16)) i_lcd_glass_model (.com_level(com_level),
        .seg_level(seg_level), .lit(lit));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] sel, input logic [23:0] data);
        @(negedge core_clk);
        pattern_we      = 1'b1;
        pattern_reg_sel = sel;
        pattern_wdata   = data;
        @(negedge core_clk);
        pattern_we = 1'b0;
    endtask
    task automatic upd();
        @(negedge core_clk);
        display_update = 1'b1;
        @(negedge core_clk);
        display_update = 1'b0;
        @(negedge core_clk);
    endtask
    // A second request while busy must be dropped, so it carries a value that would show
    task automatic conv(input logic [23:0] v, input logic [2:0] d, input logic [47:0] exp);
        @(negedge core_clk);
        number_value               = v;
        dot_position               = d;
        number_to_segments_routine = 1'b1;
        @(negedge core_clk);
        number_to_segments_routine = 1'b0;
        @(negedge core_clk);
        number_to_segments_routine = 1'b1;
        number_value               = 24'h00_0000;
        @(negedge core_clk);
        number_to_segments_routine = 1'b0;
        for (int n = 0; n < 20 && conv_busy !== 1'b0; n++) @(negedge core_clk);
        upd();
        chk(pattern_shadow, {8'hA5, exp});
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        cfg = '0;
        cfg.on_time = 3'h7;
        cfg.fast_load_divider_periods = 2'h2;
        {seg_pos_map, pattern_we, pattern_reg_sel, pattern_wdata, display_update} = '0;
        {digit_to_segment_op, digit_value, number_to_segments_routine} = '0;
        {number_value, dot_position} = '0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        for (int v = 0; v < 16; v++) begin
            @(negedge core_clk);
            digit_to_segment_op = 1'b1;
            digit_value         = v[3:0];
            @(negedge core_clk);
            digit_to_segment_op = 1'b0;
            chk(digit_segments, SEG_TBL[v]);
        end
        wr(2'h0, 24'h03_0201);
        wr(2'h1, 24'h06_0504);
        wr(2'h2, 24'h00_00A5);
        chk(pattern_shadow, 64'h0);
        upd();
        chk(pattern_shadow, 64'h00A5_0605_0403_0201);
        conv(24'h00_007B, 3'h0, 48'h0000_0006_5B4F);
        conv(24'hFF_FFFB, 3'h0, 48'h0000_0000_406D);
        conv(24'h00_04D2, 3'h2, 48'h0000_06DB_4F66);
        wr(2'h0, 24'h00_0001);
        wr(2'h1, 24'h00_0100);
        wr(2'h2, 24'h00_0000);
        upd();
        seg_pos_map = 24'h00_0003;
        for (int m = 0; m < 4; m++) begin
            cfg.mux_mode = m[1:0];
            seen = '0;
            hi = 0;
            repeat (160) begin
                @(negedge core_clk);
                seen = seen | lit;
                hi += int'(analog.low_ohm_divider);
            end
            chk(seen, m == 0 ? 64'h0 : m == 1 ? 64'h2_0000 : 64'h202_0000);
            if (m == 1) chk(hi, 64'h10);
        end
        // 48 cycles span exactly four slots of three 4-cycle units
        for (int r = 0; r < 4; r++) begin
            cfg.divider_res              = r[1:0];
            cfg.recharge_interval        = r[1:0];
            cfg.pump_charge_resistor_sel = r[0];
            hi = 0;
            repeat (4) @(negedge core_clk);
            repeat (48) begin
                @(negedge core_clk);
                hi += int'(analog.recharge_now);
            end
            chk(hi, r == 0 ? 64'h4 : r == 1 ? 64'h2 : 64'h1);
            chk(analog.divider_res, r[1:0]);
        end
        cfg.direct_drive = 1'b1;
        repeat (20) @(negedge core_clk);
        chk(analog.driver_low_res, 64'h1);
        results();
    end
endmodule
